// [rtl/gcs_pkg.sv]
// Purpose: Shared constants for the gain and channel select latch.
// Assumes: AXI4-Lite with 32-bit data and an 8-bit byte address.
// Notes: Select word layout is {gain[2:0], chan[2:0]}.
package gcs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W = 6;
  localparam int unsigned CODE_W = 3;
  localparam int unsigned POSITIONS = 8;
  localparam int unsigned GAP_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_SOFT_SEL = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // Field positions
  localparam int unsigned SEL_CHAN_LSB = 0;
  localparam int unsigned SEL_GAIN_LSB = 3;
  localparam int unsigned ST_GAIN_BUSY = 8;
  localparam int unsigned ST_CHAN_BUSY = 9;
  localparam int unsigned ST_GAIN_SW_LSB = 16;
  localparam int unsigned ST_CHAN_SW_LSB = 24;

  // Values after reset
  localparam logic [5:0] SEL_RESET = 6'h00;
  localparam logic [7:0] GAP_RESET = 8'h02;
  localparam logic [2:0] CODE_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/bbm_switch.sv]
// Purpose: One-hot analog switch driver with break-before-make.
// Assumes: code_i is stable for at least one cycle per change.
// Notes: All positions open for max(gap_i,1) cycles on each change.
`timescale 1ns/1ps
`default_nettype none
module bbm_switch #(
  parameter int unsigned POSITIONS = 8,
  parameter int unsigned GAP_W = 8
) (
  input wire logic mclk_i, // System clock
  input wire logic rst_b_i, // Async reset, active low
  input wire logic [$clog2(POSITIONS)-1:0] code_i, // Requested position
  input wire logic [GAP_W-1:0] gap_i, // Open time in cycles
  output logic [POSITIONS-1:0] sw_o, // Switch closures, one-hot
  output logic busy_o // Break in progress
);
  localparam int unsigned CW = $clog2(POSITIONS);

  if (POSITIONS < 2 || (1 << CW) != POSITIONS) begin : g_bad_pos
    $error("bbm_switch: POSITIONS must be a power of two");
  end
  if (GAP_W < 1 || GAP_W > 16) begin : g_bad_gap
    $error("bbm_switch: GAP_W out of range");
  end

  typedef enum logic [0:0] {ST_CLOSED, ST_BREAK} bbm_state_t;

  bbm_state_t state_q;
  logic [CW-1:0] cur_q;
  logic [GAP_W-1:0] cnt_q;
  logic [POSITIONS-1:0] sw_q;
  logic [POSITIONS-1:0] onehot;

  always_comb begin
    onehot = '0;
    onehot[cur_q] = 1'b1; // Single closure from the code
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_CLOSED;
      cur_q <= '0;
      cnt_q <= '0;
      sw_q <= {{(POSITIONS-1){1'b0}}, 1'b1};
    end else begin
      case (state_q)
        ST_CLOSED: begin
          if (code_i != cur_q) begin
            sw_q <= '0; // Open old position first
            cur_q <= code_i;
            cnt_q <= gap_i;
            state_q <= ST_BREAK;
          end
        end
        ST_BREAK: begin
          if (code_i != cur_q) begin
            // New request mid-break restarts the open interval
            cur_q <= code_i;
            cnt_q <= gap_i;
          end else if (cnt_q <= {{(GAP_W-1){1'b0}}, 1'b1}) begin
            sw_q <= onehot; // Close only after the gap
            state_q <= ST_CLOSED;
          end else begin
            cnt_q <= cnt_q - {{(GAP_W-1){1'b0}}, 1'b1};
          end
        end
        default: state_q <= ST_CLOSED;
      endcase
    end
  end

  assign sw_o = sw_q;
  assign busy_o = (state_q == ST_BREAK);
endmodule // bbm_switch
`default_nettype wire

// [rtl/gain_channel_select_latch.sv]
// Purpose: Select latch for a programmable-gain multiplexed amplifier.
// Assumes: Select pins and select clock are synchronous to mclk_i.
// Notes: Software may also load the word and tune the break time.
// Function
// - Capture all six select pins on a select-clock rise with enable low.
// - Gain code n selects gain 2^n, from 1 up to 128.
// - Channel code k connects analog input channel k of eight.
// - One gain position closes at a time, the one the code selects.
// - Gain switch opens the old position before closing the new one.
// - Input mux disconnects the old channel before connecting the new.
// - Gain and channel fields are independent; all 64 pairs reachable.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module gain_channel_select_latch (
  input wire logic mclk_i, // System clock, 50 MHz
  input wire logic rst_b_i, // Async reset, active low
  input wire logic chan_sel_bit0_i, // Channel select bit 0
  input wire logic chan_sel_bit1_i, // Channel select bit 1
  input wire logic chan_sel_bit2_i, // Channel select bit 2
  input wire logic gain_sel_bit0_i, // Gain select bit 0
  input wire logic gain_sel_bit1_i, // Gain select bit 1
  input wire logic gain_sel_bit2_i, // Gain select bit 2
  input wire logic sel_clk_i, // Select latch clock from host
  input wire logic sel_en_b_i, // Latch enable, active low
  output logic [7:0] gain_sw_o, // Gain positions, bit n = gain 2^n
  output logic [7:0] chan_sw_o, // Channel switches, bit k = input k
  output logic [2:0] gain_code_o, // Latched gain code
  output logic [2:0] chan_code_o, // Latched channel code
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  localparam int unsigned CW = gcs_pkg::CODE_W;
  localparam int unsigned GW = gcs_pkg::GAP_W;

  // Select pin capture
  logic sel_clk_q;
  logic [5:0] sel_q;
  logic [5:0] pin_word;
  logic pin_load;

  // Registers
  logic [GW-1:0] gap_q;
  logic soft_load;
  logic [5:0] soft_word;

  // Bus state
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic wr_config;
  logic wr_soft;
  logic gain_busy;
  logic chan_busy;
  logic [31:0] status_word;

  // Pins gathered into one word; fields kept apart
  assign pin_word = {gain_sel_bit2_i, gain_sel_bit1_i, gain_sel_bit0_i,
                     chan_sel_bit2_i, chan_sel_bit1_i, chan_sel_bit0_i};

  // Rise of the select clock with enable low at that edge
  assign pin_load = sel_clk_i && !sel_clk_q && !sel_en_b_i;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_clk_q <= 1'b0;
    end else begin
      sel_clk_q <= sel_clk_i;
    end
  end

  // Pin capture wins over a software load in the same cycle
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_q <= gcs_pkg::SEL_RESET;
    end else if (pin_load) begin
      sel_q <= pin_word;
    end else if (soft_load) begin
      sel_q <= soft_word;
    end
    // Otherwise hold, including rises with enable high
  end

  assign gain_code_o = sel_q[gcs_pkg::SEL_GAIN_LSB +: CW];
  assign chan_code_o = sel_q[gcs_pkg::SEL_CHAN_LSB +: CW];

  // Gain position n closes the 2^n feedback tap
  bbm_switch #(
    .POSITIONS(gcs_pkg::POSITIONS),
    .GAP_W(GW)
  ) u_gain_sw (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .code_i(sel_q[gcs_pkg::SEL_GAIN_LSB +: CW]),
    .gap_i(gap_q),
    .sw_o(gain_sw_o),
    .busy_o(gain_busy)
  );

  // Channel k routes analog input k to the amplifier
  bbm_switch #(
    .POSITIONS(gcs_pkg::POSITIONS),
    .GAP_W(GW)
  ) u_chan_sw (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .code_i(sel_q[gcs_pkg::SEL_CHAN_LSB +: CW]),
    .gap_i(gap_q),
    .sw_o(chan_sw_o),
    .busy_o(chan_busy)
  );

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_config = wr_fire && (aw_addr_q[7:2] == gcs_pkg::OFF_CONFIG[7:2]);
  assign wr_soft = wr_fire && (aw_addr_q[7:2] == gcs_pkg::OFF_SOFT_SEL[7:2]);
  assign soft_load = wr_soft && w_strb_q[0];
  assign soft_word = w_data_q[5:0];

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      w_hold_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= gcs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      if (wr_config || wr_soft) begin
        bresp_q <= gcs_pkg::RESP_OKAY;
      end else begin
        bresp_q <= gcs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Break time steers both switch drivers
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q <= gcs_pkg::GAP_RESET;
    end else if (wr_config && w_strb_q[0]) begin
      gap_q <= w_data_q[GW-1:0];
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[5:0] = sel_q;
    status_word[gcs_pkg::ST_GAIN_BUSY] = gain_busy;
    status_word[gcs_pkg::ST_CHAN_BUSY] = chan_busy;
    status_word[gcs_pkg::ST_GAIN_SW_LSB +: 8] = gain_sw_o;
    status_word[gcs_pkg::ST_CHAN_SW_LSB +: 8] = chan_sw_o;
  end

  assign s_axi_arready = !rvalid_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= gcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= gcs_pkg::RESP_OKAY;
      if (s_axi_araddr[7:2] == gcs_pkg::OFF_CONFIG[7:2]) begin
        rdata_q <= {{(32-GW){1'b0}}, gap_q};
      end else if (s_axi_araddr[7:2] == gcs_pkg::OFF_SOFT_SEL[7:2]) begin
        rdata_q <= {26'h000_0000, sel_q};
      end else if (s_axi_araddr[7:2] == gcs_pkg::OFF_STATUS[7:2]) begin
        rdata_q <= status_word;
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= gcs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule // gain_channel_select_latch
`default_nettype wire

// [testbench/gcs_sva.sv]
// Purpose: Checker for the select latch and its switch drivers.
// Assumes: Select clock low in reset; break time under 300 cycles.
// Notes: Sees only the top-level ports.
`timescale 1ns/1ps
`default_nettype none
module gcs_sva (
  input wire logic mclk_i, // Clock
  input wire logic rst_b_i, // Reset, active low
  input wire logic chan_sel_bit0_i, // Pin
  input wire logic chan_sel_bit1_i, // Pin
  input wire logic chan_sel_bit2_i, // Pin
  input wire logic gain_sel_bit0_i, // Pin
  input wire logic gain_sel_bit1_i, // Pin
  input wire logic gain_sel_bit2_i, // Pin
  input wire logic sel_clk_i, // Select clock
  input wire logic sel_en_b_i, // Enable, active low
  input wire logic [7:0] gain_sw_o, // Gain switch
  input wire logic [7:0] chan_sw_o, // Channel switch
  input wire logic [2:0] gain_code_o, // Gain code
  input wire logic [2:0] chan_code_o, // Channel code
  input wire logic s_axi_bvalid // Write response valid
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic clk_seen_q;
  logic take;
  logic [5:0] pins;
  logic [5:0] codes;
  assign pins = {gain_sel_bit2_i, gain_sel_bit1_i, gain_sel_bit0_i,
    chan_sel_bit2_i, chan_sel_bit1_i, chan_sel_bit0_i};
  assign codes = {gain_code_o, chan_code_o};
  assign take = sel_clk_i & ~clk_seen_q & ~sel_en_b_i;
  // Mirrors the latch's own edge detector, idle low out of reset
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_seen_q <= 1'b0;
    end else begin
      clk_seen_q <= sel_clk_i;
    end
  end
  a_capture_word: assert property (take |=> codes == $past(pins))
    else $error("select word not captured");
  a_enable_hold: assert property ($changed(codes) |->
    $past(take) || $rose(s_axi_bvalid)) else $error("codes moved");
  a_gain_match: assert property ($stable(gain_code_o) &&
    gain_sw_o != 8'h00 |-> gain_sw_o == 8'h01 << gain_code_o)
    else $error("wrong gain position");
  a_chan_match: assert property ($stable(chan_code_o) &&
    chan_sw_o != 8'h00 |-> chan_sw_o == 8'h01 << chan_code_o)
    else $error("wrong channel");
  a_gain_break: assert property ($changed(gain_code_o) |=>
    gain_sw_o == 8'h00) else $error("gain not opened first");
  a_chan_break: assert property ($changed(chan_code_o) |=>
    chan_sw_o == 8'h00) else $error("channel not opened first");
  a_gain_settle: assert property ($changed(gain_code_o) |->
    ##[2:300] gain_sw_o == 8'h01 << gain_code_o) else $error("gain late");
  a_chan_settle: assert property ($changed(chan_code_o) |->
    ##[2:300] chan_sw_o == 8'h01 << chan_code_o) else $error("chan late");
endmodule // gcs_sva
bind gain_channel_select_latch gcs_sva i_sva (.mclk_i, .rst_b_i,
  .chan_sel_bit0_i, .chan_sel_bit1_i, .chan_sel_bit2_i, .gain_sel_bit0_i,
  .gain_sel_bit1_i, .gain_sel_bit2_i, .sel_clk_i, .sel_en_b_i, .gain_sw_o,
  .chan_sw_o, .gain_code_o, .chan_code_o, .s_axi_bvalid);
`default_nettype wire

// [testbench/gcs_host_model.sv]
// Purpose: Host driving select pins, select clock and enable.
// Assumes: One request at a time from the bench.
// Notes: Pins go to the inverse word once the hold has passed.
`timescale 1ns/1ps
`default_nettype none
module gcs_host_model (
  input wire logic mclk_i, // Clock
  output logic [5:0] word_o, // {gain, chan}
  output logic sel_clk_o, // Select clock
  output logic sel_en_b_o // Enable, active low
);
  initial begin
    word_o = 6'h00;
    sel_clk_o = 1'b0;
    sel_en_b_o = 1'b1;
  end
  // Word and enable held across the rise; hi slows the host
  task automatic latch(input logic [5:0] w, input logic en_b, input int hi);
    @(posedge mclk_i);
    word_o <= w;
    sel_en_b_o <= en_b;
    sel_clk_o <= 1'b1;
    repeat (hi) @(posedge mclk_i);
    @(posedge mclk_i);
    sel_clk_o <= 1'b0;
    sel_en_b_o <= 1'b1;
    word_o <= ~w;
  endtask
endmodule // gcs_host_model
`default_nettype wire

// [testbench/gain_channel_select_latch_tb_top.sv]
// Purpose: Self-checking bench for the select latch.
// Assumes: Break time register defaults to two cycles.
// Notes: AXI sampled on the falling edge, driven on the rising.
`timescale 1ns/1ps
`default_nettype none
module gain_channel_select_latch_tb_top;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [5:0] word;
  logic sel_clk_i, sel_en_b_i;
  logic [7:0] gain_sw_o, chan_sw_o;
  logic [2:0] gain_code_o, chan_code_o;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  int m;
  always #10 mclk_i = ~mclk_i;
  gcs_host_model i_host (.mclk_i, .word_o(word), .sel_clk_o(sel_clk_i),
    .sel_en_b_o(sel_en_b_i));
  gain_channel_select_latch i_dut (.mclk_i, .rst_b_i,
    .chan_sel_bit0_i(word[0]), .chan_sel_bit1_i(word[1]),
    .chan_sel_bit2_i(word[2]), .gain_sel_bit0_i(word[3]),
    .gain_sel_bit1_i(word[4]), .gain_sel_bit2_i(word[5]), .sel_clk_i,
    .sel_en_b_i, .gain_sw_o, .chan_sw_o, .gain_code_o, .chan_code_o,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic dn, ta, tw, tr;
    dn = 1'b0;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (int k = 0; k < 30 && !dn; k++) begin
      @(negedge mclk_i);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      r = w ? s_axi_bresp : s_axi_rresp;
      @(posedge mclk_i);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      if (dn) s_axi_bready <= 1'b0;
      if (dn) s_axi_rready <= 1'b0;
    end
    chk("axi answer", dn, 1'b1);
  endtask
  // Counts open gain and channel cycles until both show the word
  task automatic settle(input logic [5:0] e);
    n = 0;
    m = 0;
    for (int k = 0; k < 300; k++) begin
      @(negedge mclk_i);
      if (gain_sw_o === 8'h00) n++;
      if (chan_sw_o === 8'h00) m++;
      if (k >= 2 && gain_sw_o === 8'h01 << e[5:3] &&
          chan_sw_o === 8'h01 << e[2:0]) break;
    end
    chk("gain_sw", gain_sw_o, 8'h01 << e[5:3]);
    chk("chan_sw", chan_sw_o, 8'h01 << e[2:0]);
    chk("codes", {gain_code_o, chan_code_o}, e);
  endtask
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    settle(6'h00);
    axi(1'b0, gcs_pkg::OFF_CONFIG, 32'h0);
    chk("config", q, {24'h0, gcs_pkg::GAP_RESET});
    axi(1'b0, 8'h0C, 32'h0);
    chk("unmapped resp", r, gcs_pkg::RESP_SLVERR);
    chk("unmapped data", q, 32'h0);
    for (int i = 0; i < 64; i++) begin
      i_host.latch(6'(i), 1'b0, i % 3);
      settle(6'(i));
    end
    i_host.latch(6'h15, 1'b1, 0);
    repeat (4) @(negedge mclk_i);
    chk("held", {gain_code_o, chan_code_o}, 6'h3F);
    axi(1'b0, gcs_pkg::OFF_STATUS, 32'h0);
    chk("status", q, 32'h8080_003F);
    axi(1'b1, gcs_pkg::OFF_CONFIG, 32'h5);
    i_host.latch(6'h00, 1'b0, 0);
    settle(6'h00);
    chk("break", n, 5);
    chk("chan break", m, 5);
    axi(1'b1, gcs_pkg::OFF_CONFIG, 32'h0);
    i_host.latch(6'h09, 1'b0, 0);
    settle(6'h09);
    chk("short break", n, 1);
    chk("short chan break", m, 1);
    axi(1'b1, gcs_pkg::OFF_STATUS, 32'h3F);
    chk("ro resp", r, gcs_pkg::RESP_SLVERR);
    axi(1'b1, gcs_pkg::OFF_SOFT_SEL, 32'h2D);
    chk("soft resp", r, gcs_pkg::RESP_OKAY);
    settle(6'h2D);
    axi(1'b0, gcs_pkg::OFF_SOFT_SEL, 32'h0);
    chk("soft read", q, 32'h2D);
    // Low strobe bit masks the load but still answers OKAY
    s_axi_wstrb <= 4'h0;
    axi(1'b1, gcs_pkg::OFF_SOFT_SEL, 32'h12);
    chk("masked resp", r, gcs_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi(1'b0, gcs_pkg::OFF_SOFT_SEL, 32'h0);
    chk("masked word", q, 32'h2D);
    rst_b_i <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk("reset codes", {gain_code_o, chan_code_o}, 6'h00);
    chk("reset gain_sw", gain_sw_o, 8'h01);
    chk("reset chan_sw", chan_sw_o, 8'h01);
    close_out;
  end
  // Whole run needs about 400 cycles
  initial begin
    #400000;
    n_fail++;
    close_out;
  end
endmodule // gain_channel_select_latch_tb_top
`default_nettype wire
